// file: rtl/fco_consts.svh
// Notes on behaviour
// - Low-level alarm when rate exceeds half threshold.
// - Lockout output follows saturation lockout condition.
// - Panel or external accept clears latched alarm.
// - External inhibit resets state, disables fire outputs.
// - Outputs-inhibited active whenever outputs are disabled.
// - Fault output on normally, off on fault.
// - Four zone outputs, one per fire zone.
// - Status lines copy zone and status displays.
// - Zone number 1-8 binary on lines 1-4.
// - Data output bus feeds next controller input.
// - Data sync output feeds slave chain request.
// - Chain request driven by last controller's sync.
// - Latching zone and fire outputs; clear on reset/inhibit.
// - Threshold sums switch weights 8/16/32/64, floor 8.
// - Status digit 0-9 mapped onto upper lines.
`ifndef FCO_CONSTS_SVH
`define FCO_CONSTS_SVH
`define FCO_CLK_MHZ     125
`define FCO_FILT_NS     1000
`define FCO_FILT_CYC    ((`FCO_FILT_NS * `FCO_CLK_MHZ + 999) / 1000)
`define FCO_SENS_W0     8
`define FCO_SENS_W1     16
`define FCO_SENS_W2     32
`define FCO_SENS_W3     64
`define FCO_SENS_FLOOR  8
`define FCO_ZONE_MAX    4'h8
`define FCO_RST_OC      18'h0
`endif

// file: rtl/fco_pkg.sv
package fco_pkg;
  // Open-collector output bundle; a set bit means the pin is pulled low (active).
  typedef struct packed {
    logic [7:0] status;
    logic       fault;
    logic       inhibited;
    logic       alarm;
    logic       fireLogic;
    logic       lockout;
    logic       lowAlarm;
    logic [3:0] zone;
  } fco_oc_t;

  typedef enum logic [1:0] {
    FCO_TX_IDLE = 2'b00,
    FCO_TX_SYNC = 2'b01,
    FCO_TX_HOLD = 2'b10
  } fco_tx_t;

  // Returns {inhibitedBit, faultBit, S8, S7, S6, S5} for a status digit.
  function automatic logic [5:0] fco_status_code(input logic [3:0] digit);
    logic [5:0] code;
    code = 6'h00;
    case (digit)
      4'h0: code = 6'h20;
      4'h1: code = 6'h22;
      4'h2: code = 6'h04;
      4'h3: code = 6'h16;
      4'h4: code = 6'h08;
      4'h5: code = 6'h0A;
      4'h6: code = 6'h1C;
      4'h7: code = 6'h1E;
      4'h8: code = 6'h20;
      4'h9: code = 6'h23;
      default: code = 6'h00;
    endcase
    return code;
  endfunction : fco_status_code
endpackage : fco_pkg

// file: rtl/fco_if.sv
`timescale 1ns/1ps
interface fco_if;
  import fco_pkg::*;
  fco_oc_t    ocOut;
  fco_oc_t    ocOe;
  fco_oc_t    ocLevelN;
  logic       inhOut;
  logic       inhOe;
  logic       accOut;
  logic       accOe;
  logic       extInhibitN;
  logic       extAcceptN;
  logic [7:0] dataOut;
  logic [7:0] dataIn;
  logic       dataSync;
  logic       chainIn;
  logic       chain_out_avail;
  logic       chain_in_avail;

  // Pulled-up open-collector wires: low only where a driver enables a low output.
  assign ocLevelN    = ~(ocOe & ~ocOut);
  assign extInhibitN = ~(inhOe & ~inhOut);
  assign extAcceptN  = ~(accOe & ~accOut);

  modport device (output ocOut, ocOe, dataOut, dataSync, chain_out_avail, chain_in_avail,
                  input extInhibitN, extAcceptN, dataIn, chainIn);
  modport partner (output inhOut, inhOe, accOut, accOe, dataIn, chainIn,
                   input ocLevelN, dataOut, dataSync, chain_out_avail, chain_in_avail);
endinterface : fco_if

// file: rtl/fco_device.sv
`timescale 1ns/1ps
`include "fco_consts.svh"
module fco_device
  import fco_pkg::*;
#(
  parameter int RATE_W = 10,
  parameter int FILT_CYC = `FCO_FILT_CYC
) (
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              nrst,
  // Link to annunciation and chain.
  fco_if.device                  link,
  // Detection results.
  input  wire logic [3:0]        zoneReq,
  input  wire logic              fireReq,
  input  wire logic              satLockout,
  input  wire logic [RATE_W-1:0] countRate,
  // Switch settings.
  input  wire logic [3:0]        sensSw,
  input  wire logic              latchEn,
  // Front panel and supervision.
  input  wire logic              keyReset,
  input  wire logic              panelAccept,
  input  wire logic              localDisable,
  input  wire logic              faultCond,
  input  wire logic [3:0]        zoneDigit,
  input  wire logic [3:0]        statusDigit,
  output logic                   statusFaultBit,
  output logic                   statusInhBit,
  // Chain user side.
  input  wire logic [7:0]        txData,
  input  wire logic              txValid,
  output logic                   txReady,
  output logic [7:0]             rxData,
  output logic                   rxValid,
  input  wire logic              rxEnable
);
  localparam int FW = $clog2(FILT_CYC + 1);

  // Input conditioning.
  // A bounce on a closure shorter than the filter time never reaches the outputs.
  logic [1:0]    inhSync_q, inhSync_d, accSync_q, accSync_d;
  logic          inhAct_q, inhAct_d, accAct_q, accAct_d;
  logic [FW-1:0] inhCnt_q, inhCnt_d, accCnt_q, accCnt_d;

  always_comb begin
    inhSync_d = {inhSync_q[0], ~link.extInhibitN};
    accSync_d = {accSync_q[0], ~link.extAcceptN};
    inhCnt_d  = inhCnt_q;
    accCnt_d  = accCnt_q;
    inhAct_d  = inhAct_q;
    accAct_d  = accAct_q;
    // A level must hold for the whole filter time before it is believed.
    if (inhSync_q[1] == inhAct_q) begin
      inhCnt_d = '0;
    end else if (inhCnt_q == FW'(FILT_CYC - 1)) begin
      inhCnt_d = '0;
      inhAct_d = inhSync_q[1];
    end else begin
      inhCnt_d = inhCnt_q + FW'(1);
    end
    if (accSync_q[1] == accAct_q) begin
      accCnt_d = '0;
    end else if (accCnt_q == FW'(FILT_CYC - 1)) begin
      accCnt_d = '0;
      accAct_d = accSync_q[1];
    end else begin
      accCnt_d = accCnt_q + FW'(1);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      inhSync_q <= 2'h0;
      accSync_q <= 2'h0;
      inhCnt_q  <= '0;
      accCnt_q  <= '0;
      inhAct_q  <= 1'b0;
      accAct_q  <= 1'b0;
    end else begin
      inhSync_q <= inhSync_d;
      accSync_q <= accSync_d;
      inhCnt_q  <= inhCnt_d;
      accCnt_q  <= accCnt_d;
      inhAct_q  <= inhAct_d;
      accAct_q  <= accAct_d;
    end
  end

  // Output state.
  // Fault is the one pin that is active at rest, so a dead board reads as a fault.
  logic [3:0]        zoneOn_q, zoneOn_d;
  logic              fireOn_q, fireOn_d, alarm_q, alarm_d;
  logic [RATE_W+1:0] thresh;
  logic              disabled;
  fco_oc_t           oc_q, oc_d;
  logic [5:0]        code;
  logic              stFault_q, stFault_d, stInh_q, stInh_d;

  always_comb begin
    thresh = (RATE_W + 2)'((sensSw[0] ? `FCO_SENS_W0 : 0) + (sensSw[1] ? `FCO_SENS_W1 : 0)
           + (sensSw[2] ? `FCO_SENS_W2 : 0) + (sensSw[3] ? `FCO_SENS_W3 : 0));
    if (thresh < (RATE_W + 2)'(`FCO_SENS_FLOOR)) begin
      thresh = (RATE_W + 2)'(`FCO_SENS_FLOOR);
    end
    disabled = inhAct_q | localDisable;
    zoneOn_d = latchEn ? (zoneOn_q | zoneReq) : zoneReq;
    fireOn_d = latchEn ? (fireOn_q | fireReq) : fireReq;
    // The set term wins, so a zone turning on during an accept is not lost.
    alarm_d  = ((panelAccept | accAct_q) ? 1'b0 : alarm_q) | (|zoneOn_d);
    if (keyReset | inhAct_q) begin
      zoneOn_d = 4'h0;
      fireOn_d = 1'b0;
      alarm_d  = 1'b0;
    end
    code           = fco_status_code(statusDigit);
    stFault_d      = code[4];
    stInh_d        = code[5];
    oc_d           = `FCO_RST_OC;
    oc_d.zone      = disabled ? 4'h0 : zoneOn_d;
    oc_d.fireLogic = fireOn_d & ~disabled;
    oc_d.alarm     = alarm_d & ~disabled;
    oc_d.lowAlarm  = ({2'b00, countRate} << 1) > thresh;
    oc_d.lockout   = satLockout;
    oc_d.inhibited = disabled;
    oc_d.fault     = ~faultCond;
    oc_d.status[3:0] = (zoneDigit >= 4'h1 && zoneDigit <= `FCO_ZONE_MAX) ? zoneDigit : 4'h0;
    // Line 5 takes the lowest bit of the status code, line 8 the highest.
    oc_d.status[7:4] = code[3:0];
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      zoneOn_q  <= 4'h0;
      fireOn_q  <= 1'b0;
      alarm_q   <= 1'b0;
      oc_q      <= `FCO_RST_OC;
      stFault_q <= 1'b0;
      stInh_q   <= 1'b0;
    end else begin
      zoneOn_q  <= zoneOn_d;
      fireOn_q  <= fireOn_d;
      alarm_q   <= alarm_d;
      oc_q      <= oc_d;
      stFault_q <= stFault_d;
      stInh_q   <= stInh_d;
    end
  end

  // Pins only ever pull low; an inactive pin is released.
  assign link.ocOut     = `FCO_RST_OC;
  assign link.ocOe      = oc_q;

  // The fault and inhibit columns of the status code go to the panel, not to pins.
  assign statusFaultBit = stFault_q;
  assign statusInhBit   = stInh_q;

  // Chain transfer.
  // Bytes are only taken from idle, so one leaves at most every third cycle.
  // A user that needs more throughput must buffer outside this block.
  fco_tx_t    tx_q, tx_d;
  logic [7:0] dOut_q, dOut_d, rx_q, rx_d;
  logic       rxV_q, rxV_d, chIn_q, chIn_d;

  always_comb begin
    tx_d    = tx_q;
    dOut_d  = dOut_q;
    chIn_d  = link.chainIn;
    rx_d    = rx_q;
    rxV_d   = 1'b0;
    txReady = (tx_q == FCO_TX_IDLE);
    unique case (tx_q)
      FCO_TX_IDLE: begin
        if (txValid) begin
          dOut_d = txData;
          tx_d   = FCO_TX_SYNC;
        end
      end
      FCO_TX_SYNC: tx_d = FCO_TX_HOLD;
      FCO_TX_HOLD: tx_d = FCO_TX_IDLE;
    endcase
    // Each rising request edge from the ring takes one byte while rxEnable is high.
    if (rxEnable && link.chainIn && !chIn_q) begin
      rx_d  = link.dataIn;
      rxV_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_q   <= FCO_TX_IDLE;
      dOut_q <= 8'h00;
      rx_q   <= 8'h00;
      rxV_q  <= 1'b0;
      chIn_q <= 1'b0;
    end else begin
      tx_q   <= tx_d;
      dOut_q <= dOut_d;
      rx_q   <= rx_d;
      rxV_q  <= rxV_d;
      chIn_q <= chIn_d;
    end
  end

  assign link.dataOut         = dOut_q;
  assign link.dataSync        = (tx_q == FCO_TX_SYNC);
  assign link.chain_out_avail = (tx_q != FCO_TX_IDLE);
  assign link.chain_in_avail  = rxEnable;
  assign rxData               = rx_q;
  assign rxValid              = rxV_q;
endmodule : fco_device

// file: rtl/fco_partner.sv
`timescale 1ns/1ps
`include "fco_consts.svh"
module fco_partner
  import fco_pkg::*;
(
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Link to the controller.
  fco_if.partner          link,
  // Annunciator controls.
  input  wire logic       inhibitReq,
  input  wire logic       acceptReq,
  output fco_oc_t         ocSeen,
  // Neighbour chain side.
  input  wire logic [7:0] nbTxData,
  input  wire logic       nbTxValid,
  output logic            nbTxReady,
  output logic [7:0]      nbRxData,
  output logic            nbRxValid
);
  fco_oc_t    seen_q, seen_d;
  logic [7:0] dIn_q, dIn_d, rx_q, rx_d;
  logic       req_q, req_d, rxV_q, rxV_d;

  always_comb begin
    seen_d = ~link.ocLevelN;
    dIn_d  = dIn_q;
    req_d  = 1'b0;
    rx_d   = rx_q;
    rxV_d  = 1'b0;
    // One request pulse per byte, and only while the controller accepts bytes.
    nbTxReady = link.chain_in_avail & ~req_q;
    if (nbTxValid && nbTxReady) begin
      dIn_d = nbTxData;
      req_d = 1'b1;
    end
    if (link.dataSync) begin
      rx_d  = link.dataOut;
      rxV_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seen_q <= `FCO_RST_OC;
      dIn_q  <= 8'h00;
      req_q  <= 1'b0;
      rx_q   <= 8'h00;
      rxV_q  <= 1'b0;
    end else begin
      seen_q <= seen_d;
      dIn_q  <= dIn_d;
      req_q  <= req_d;
      rx_q   <= rx_d;
      rxV_q  <= rxV_d;
    end
  end

  // Inhibit and accept are switch closures to ground.
  assign link.inhOut = 1'b0;
  assign link.inhOe  = inhibitReq;
  assign link.accOut = 1'b0;
  assign link.accOe  = acceptReq;
  assign link.dataIn  = dIn_q;
  assign link.chainIn = req_q;
  assign ocSeen    = seen_q;
  assign nbRxData  = rx_q;
  assign nbRxValid = rxV_q;
endmodule : fco_partner

// file: tb/fco_assertions.sv
`timescale 1ns/1ps
module fco_assertions
  import fco_pkg::*;
#(
  parameter int FILT_CYC = 2
) (
  // Clock and reset.
  input wire logic       mclk,
  input wire logic       nrst,
  // Link signals.
  input wire fco_oc_t    ocOut,
  input wire fco_oc_t    ocOe,
  input wire logic       extInhibitN,
  input wire logic       extAcceptN,
  input wire logic [7:0] dataOut,
  input wire logic       dataSync,
  input wire logic       chainIn,
  input wire logic       chain_out_avail
);
  // Two sync stages, the filter, the state and the pin register all fit in this margin.
  localparam int SETTLE = FILT_CYC + 5;
  int inhCnt_q;
  int inhCnt_d;
  int accCnt_q;
  int accCnt_d;
  always_comb begin
    inhCnt_d = extInhibitN ? 0 : inhCnt_q + int'(inhCnt_q < 1000);
    accCnt_d = extAcceptN ? 0 : accCnt_q + int'(accCnt_q < 1000);
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      inhCnt_q <= 0;
      accCnt_q <= 0;
    end else begin
      inhCnt_q <= inhCnt_d;
      accCnt_q <= accCnt_d;
    end
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence frameSeq;
    chain_out_avail ##1 (chain_out_avail && !dataSync) ##1 !chain_out_avail;
  endsequence
  sync_frame_a: assert property (dataSync |-> frameSeq)
    else $error("chain frame shape wrong");
  data_hold_a: assert property (dataSync |=> $stable(dataOut))
    else $error("chain byte changed in frame");
  alarm_follow_a: assert property (ocOe.zone != 4'h0 |-> ocOe.alarm)
    else $error("zone active without alarm");
  inhibit_mute_a: assert property (inhCnt_q > SETTLE |-> ocOe.inhibited &&
    ocOe.zone == 4'h0 && !ocOe.alarm && !ocOe.fireLogic) else $error("inhibit ignored");
  accept_clear_a: assert property ((accCnt_q > SETTLE && ocOe.zone == 4'h0)[*3]
    |-> !ocOe.alarm) else $error("accept did not clear alarm");
  inhibited_quiet_a: assert property (ocOe.inhibited |-> ocOe.zone == 4'h0)
    else $error("zone active while inhibited");
  open_drain_a: assert property (ocOut == 18'h0)
    else $error("output pin driven high");
  chain_req_a: assert property (chainIn |=> !chainIn)
    else $error("chain request longer than one cycle");
endmodule : fco_assertions

// file: tb/fco_bench.sv
`timescale 1ns/1ps
module fco_bench;
  import fco_pkg::*;
  localparam int FILT = 2;
  // The whole sequence needs about 85 cycles; the watchdog allows far more.
  localparam int TIMEOUT_NS = 20000;
  typedef struct packed {
    logic [3:0]  zone;
    logic        fire;
    logic        sat;
    logic [9:0]  rate;
    logic [3:0]  sens;
    logic        flt;
    logic [3:0]  zd;
    logic [3:0]  sd;
    logic [17:0] oe;
    logic [1:0]  fi;
  } fco_row_t;
  logic       mclk = 1'b0;
  logic       nrst, fireReq, satLockout, latchEn, keyReset, panelAccept, localDisable;
  logic       faultCond, txValid, rxEnable, inhibitReq, acceptReq, nbTxValid;
  logic       statusFaultBit, statusInhBit, txReady, rxValid, nbTxReady, nbRxValid;
  logic [3:0] zoneReq, sensSw, zoneDigit, statusDigit;
  logic [9:0] countRate;
  logic [7:0] txData, rxData, nbTxData, nbRxData;
  fco_oc_t    ocSeen;
  fco_row_t   r;
  int         err_total = 0;
  int         cmp_count = 0;
  fco_row_t   rows[10] = '{
    '{4'h0, 1'b0, 1'b0, 10'h004, 4'h0, 1'b0, 4'h1, 4'h1, 18'h08600, 2'h1},
    '{4'h0, 1'b0, 1'b1, 10'h005, 4'h0, 1'b0, 4'h8, 4'h9, 18'h0E230, 2'h1},
    '{4'h0, 1'b0, 1'b0, 10'h03C, 4'hF, 1'b1, 4'h9, 4'h3, 18'h18000, 2'h2},
    '{4'h0, 1'b0, 1'b0, 10'h03D, 4'hF, 1'b0, 4'h0, 4'h6, 18'h30210, 2'h2},
    '{4'h0, 1'b0, 1'b0, 10'h009, 4'h2, 1'b0, 4'h5, 4'h8, 18'h01610, 2'h1},
    '{4'h5, 1'b1, 1'b0, 10'h000, 4'h0, 1'b0, 4'h3, 4'h2, 18'h10EC5, 2'h0},
    '{4'h0, 1'b0, 1'b0, 10'h000, 4'h0, 1'b0, 4'h2, 4'h7, 18'h38A80, 2'h2},
    '{4'h0, 1'b0, 1'b0, 10'h000, 4'h0, 1'b0, 4'h4, 4'h4, 18'h21280, 2'h0},
    '{4'h0, 1'b0, 1'b0, 10'h000, 4'h0, 1'b0, 4'h6, 4'h5, 18'h29A80, 2'h0},
    '{4'h0, 1'b0, 1'b0, 10'h000, 4'h0, 1'b0, 4'hA, 4'h0, 18'h00280, 2'h1}};
  fco_if link ();
  fco_device #(.FILT_CYC(FILT)) u_fco_device (.mclk, .nrst, .link, .zoneReq, .fireReq,
    .satLockout, .countRate, .sensSw, .latchEn, .keyReset, .panelAccept, .localDisable,
    .faultCond, .zoneDigit, .statusDigit, .statusFaultBit, .statusInhBit, .txData, .txValid,
    .txReady, .rxData, .rxValid, .rxEnable);
  fco_partner u_fco_partner (.mclk, .nrst, .link, .inhibitReq, .acceptReq, .ocSeen,
    .nbTxData, .nbTxValid, .nbTxReady, .nbRxData, .nbRxValid);
  fco_assertions #(.FILT_CYC(FILT)) u_fco_assertions (.mclk, .nrst, .ocOut(link.ocOut),
    .ocOe(link.ocOe), .extInhibitN(link.extInhibitN), .extAcceptN(link.extAcceptN),
    .dataOut(link.dataOut), .dataSync(link.dataSync), .chainIn(link.chainIn),
    .chain_out_avail(link.chain_out_avail));
  always #4 mclk = ~mclk;
  task automatic chk_oe(input fco_oc_t got, input fco_oc_t exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_oe
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic wait_hi(ref logic f);
    int i;
    i = 0;
    while (f !== 1'b1 && i < 20) begin
      @(negedge mclk);
      i++;
    end
    chk_val({7'h0, f}, 8'h01);
  endtask : wait_hi
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial begin
    #(TIMEOUT_NS);
    err_total++;
    tally_and_finish();
  end
  initial begin
    nrst = 1'b0;
    {zoneReq, fireReq, satLockout, countRate, sensSw, latchEn, keyReset, panelAccept} = '0;
    {localDisable, faultCond, zoneDigit, statusDigit, txData, txValid, inhibitReq} = '0;
    {acceptReq, nbTxData, nbTxValid} = '0;
    rxEnable = 1'b1;
    cyc(12);
    nrst = 1'b1;
    cyc(1);
    foreach (rows[i]) begin
      r = rows[i];
      {zoneReq, fireReq, satLockout, countRate, sensSw} = {r.zone, r.fire, r.sat, r.rate, r.sens};
      {faultCond, zoneDigit, statusDigit} = {r.flt, r.zd, r.sd};
      cyc(1);
      chk_oe(link.ocOe, r.oe);
      chk_val({6'h0, statusFaultBit, statusInhBit}, {6'h0, r.fi});
    end
    cyc(1);
    chk_oe(ocSeen, rows[9].oe);
    $display("status table test done");
    panelAccept = 1'b1;
    cyc(1);
    panelAccept = 1'b0;
    cyc(1);
    chk_val({7'h0, link.ocOe.alarm}, 8'h00);
    zoneReq = 4'h8;
    cyc(1);
    zoneReq = 4'h0;
    cyc(3);
    chk_val({7'h0, link.ocOe.alarm}, 8'h01);
    acceptReq = 1'b1;
    cyc(1);
    acceptReq = 1'b0;
    cyc(FILT + 6);
    chk_val({7'h0, link.ocOe.alarm}, 8'h01);
    acceptReq = 1'b1;
    cyc(FILT + 9);
    chk_val({7'h0, link.ocOe.alarm}, 8'h00);
    acceptReq = 1'b0;
    $display("alarm accept test done");
    latchEn = 1'b1;
    {zoneReq, fireReq} = {4'h2, 1'b1};
    cyc(1);
    {zoneReq, fireReq} = {4'h0, 1'b0};
    cyc(3);
    chk_val({3'h0, link.ocOe.fireLogic, link.ocOe.zone}, 8'h12);
    inhibitReq = 1'b1;
    cyc(FILT + 6);
    chk_val({1'b0, link.ocOe.inhibited, link.ocOe.alarm, link.ocOe.fireLogic,
             link.ocOe.zone}, 8'h40);
    inhibitReq = 1'b0;
    cyc(FILT + 6);
    chk_val({2'h0, link.ocOe.inhibited, link.ocOe.fireLogic, link.ocOe.zone}, 8'h00);
    zoneReq = 4'h1;
    cyc(1);
    zoneReq = 4'h0;
    keyReset = 1'b1;
    cyc(1);
    keyReset = 1'b0;
    cyc(1);
    chk_val({4'h0, link.ocOe.zone}, 8'h00);
    localDisable = 1'b1;
    cyc(2);
    chk_val({3'h0, link.ocOe.inhibited, link.ocOe.zone}, 8'h10);
    {localDisable, latchEn} = 2'h0;
    $display("latch and inhibit test done");
    nrst = 1'b0;
    cyc(1);
    chk_oe(link.ocOe, 18'h0);
    nrst = 1'b1;
    cyc(2);
    chk_val({7'h0, link.ocOe.fault}, 8'h01);
    $display("mid-run reset test done");
    {txData, txValid} = {8'hA5, 1'b1};
    cyc(1);
    chk_val({7'h0, txReady}, 8'h00);
    txValid = 1'b0;
    wait_hi(nbRxValid);
    chk_val(nbRxData, 8'hA5);
    {nbTxData, nbTxValid} = {8'h3C, 1'b1};
    cyc(1);
    chk_val({7'h0, nbTxReady}, 8'h00);
    nbTxValid = 1'b0;
    wait_hi(rxValid);
    chk_val(rxData, 8'h3C);
    rxEnable = 1'b0;
    cyc(1);
    chk_val({7'h0, link.chain_in_avail}, 8'h00);
    $display("chain test done");
    tally_and_finish();
  end
endmodule : fco_bench
